/* host_strobe_detect.sv */
// host strobe detector: turns chip select, read and write into start pulses
// assumes: host pins are synchronous to i_clk, all strobes active low
`timescale 1ns/1ps
`default_nettype none
module host_strobe_detect (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_cs_n,
  input  wire logic i_rd_n,
  input  wire logic i_wr_n,
  output logic      o_rd_active,
  output logic      o_rd_start,
  output logic      o_wr_start
);
  logic rd_prev;
  logic wr_prev;
  logic wr_active;

  // one pulse per access: a long strobe never repeats its side effect
  assign o_rd_active = ~i_cs_n & ~i_rd_n;
  assign wr_active   = ~i_cs_n & ~i_wr_n;
  assign o_rd_start  = o_rd_active & ~rd_prev;
  assign o_wr_start  = wr_active & ~wr_prev;

  // remember last cycle's strobe levels
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end else begin
      rd_prev <= o_rd_active;
      wr_prev <= wr_active;
    end
  end
endmodule
`default_nettype wire

/* modem_host_port_pkg.sv */
// package: register numbers, bit positions, reset values of the host port
// assumes: used by the host port top only; its two helper modules do not import it
package modem_host_port_pkg;
  // ----------------------------------------------------------------------
  // register numbers on the 3-bit host address
  // ----------------------------------------------------------------------
  localparam logic [2:0] REG_RAM_DATA_LOW      = 3'h0;
  localparam logic [2:0] REG_RAM_DATA_HIGH     = 3'h1;
  localparam logic [2:0] REG_RAM_ADDRESS_LOW   = 3'h2;
  localparam logic [2:0] REG_PARALLEL_LINK     = 3'h3;
  localparam logic [2:0] REG_RAM_CONTROL       = 3'h4;
  localparam logic [2:0] REG_PUMP_STATUS       = 3'h5;
  localparam logic [2:0] REG_UNASSIGNED        = 3'h6;
  localparam logic [2:0] REG_FRAME_STATUS      = 3'h7;

  // ----------------------------------------------------------------------
  // ram_control bit positions
  // ----------------------------------------------------------------------
  localparam int CTL_ADDR_TOP   = 0;
  localparam int CTL_REQUEST    = 1;
  localparam int CTL_DIRECTION  = 2;
  localparam int CTL_SEND_REQ   = 3;
  localparam int CTL_PARALLEL   = 4;
  localparam int CTL_RAM_IE     = 5;
  localparam int CTL_RX_IE      = 6;
  localparam int CTL_TX_IE      = 7;

  // ----------------------------------------------------------------------
  // pump_status bit positions
  // ----------------------------------------------------------------------
  localparam int STS_IN_RESET   = 0;
  localparam int STS_CARRIER    = 1;
  localparam int STS_RETRAIN    = 2;
  localparam int STS_PUMP_BUSY  = 4;
  localparam int STS_RAM_DONE   = 5;
  localparam int STS_RX_BYTE    = 6;
  localparam int STS_TX_BYTE    = 7;

  // ----------------------------------------------------------------------
  // reset values and widths
  // ----------------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET   = 8'h00;
  localparam logic [7:0] BYTE_RESET      = 8'h00;
  localparam logic       RX_FLAG_RESET   = 1'b1;
  localparam int         FRAME_BITS      = 3;
  localparam logic [2:0] FRAME_RESET     = 3'h0;
  localparam logic       MARK_LEVEL      = 1'b1;
endpackage

/* modem_host_register_port.sv */
// modem host register port: byte-wide register file seen by the host cpu
// assumes: host pins synchronous to i_clk; pump core answers ram requests
`timescale 1ns/1ps
`default_nettype none
module modem_host_register_port #(
  parameter logic [7:0] FW_VERSION = 8'h01  // arbitrary value
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_host_addr,
  input  wire logic [7:0] i_host_data,
  output logic      [7:0] o_host_data,
  output logic            o_host_data_oe_n,
  input  wire logic       i_host_cs_n,
  input  wire logic       i_host_rd_n,
  input  wire logic       i_host_wr_n,
  output logic            o_host_irq_n,
  output logic            o_ram_req,
  output logic            o_ram_we,
  output logic      [8:0] o_ram_addr,
  output logic     [15:0] o_ram_wdata,
  input  wire logic       i_ram_ack,
  input  wire logic [15:0] i_ram_rdata,
  input  wire logic       i_rx_byte_valid,
  input  wire logic [7:0] i_rx_byte,
  output logic      [7:0] o_tx_byte,
  input  wire logic       i_tx_byte_taken,
  output logic            o_parallel_path_select,
  input  wire logic       i_rts_n,
  output logic            o_send_request,
  input  wire logic       i_standby,
  input  wire logic       i_pump_in_reset,
  input  wire logic       i_carrier_detect,
  input  wire logic       i_retrain,
  input  wire logic       i_pump_busy,
  input  wire logic [2:0] i_frame_status,
  output logic      [2:0] o_frame_control,
  input  wire logic       i_rx_serial,
  output logic            o_rx_serial,
  output logic            o_line_signal_detect_n
);
  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [7:0] ram_word_low_byte;
  logic [7:0] ram_word_high_byte;
  logic [7:0] ram_addr_low_byte;
  logic [7:0] parallel_link_byte;
  logic [7:0] ram_control;
  logic       ram_done_flag;
  logic       rx_byte_flag;
  logic       tx_byte_flag;
  logic [2:0] frame_control;
  logic       version_pending;

  logic       rd_active;
  logic       rd_start;
  logic       wr_start;
  logic       ram_done;
  logic       seq_req;

  // ----------------------------------------------------------------------
  // strobe detection and ram sequencing
  // ----------------------------------------------------------------------
  host_strobe_detect strobes (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_cs_n      (i_host_cs_n),
    .i_rd_n      (i_host_rd_n),
    .i_wr_n      (i_host_wr_n),
    .o_rd_active (rd_active),
    .o_rd_start  (rd_start),
    .o_wr_start  (wr_start)
  );

  // decode used for every register write and read
  function automatic logic hit(input logic [2:0] num, input logic [2:0] sel);
    hit = (num == sel);
  endfunction

  // ----------------------------------------------------------------------
  // write and read decode
  // ----------------------------------------------------------------------
  logic wr_low;
  logic wr_high;
  logic wr_addr;
  logic wr_link;
  logic wr_ctrl;
  logic wr_frame;
  logic rd_link;
  logic ram_start;
  logic parallel;
  logic rx_take;
  logic tx_take;
  logic load_version;

  // register 6 has no write strobe at all, so writes vanish
  assign wr_low   = wr_start & hit(i_host_addr,
                      modem_host_port_pkg::REG_RAM_DATA_LOW);
  assign wr_high  = wr_start & hit(i_host_addr,
                      modem_host_port_pkg::REG_RAM_DATA_HIGH);
  assign wr_addr  = wr_start & hit(i_host_addr,
                      modem_host_port_pkg::REG_RAM_ADDRESS_LOW);
  assign wr_link  = wr_start & hit(i_host_addr,
                      modem_host_port_pkg::REG_PARALLEL_LINK);
  assign wr_ctrl  = wr_start & hit(i_host_addr,
                      modem_host_port_pkg::REG_RAM_CONTROL);
  assign wr_frame = wr_start & hit(i_host_addr,
                      modem_host_port_pkg::REG_FRAME_STATUS);
  assign rd_link  = rd_start & hit(i_host_addr,
                      modem_host_port_pkg::REG_PARALLEL_LINK);

  // a request starts when the host writes the request bit as one
  assign ram_start = wr_ctrl
                   & i_host_data[modem_host_port_pkg::CTL_REQUEST];
  assign parallel  = ram_control[modem_host_port_pkg::CTL_PARALLEL];
  assign rx_take   = parallel & i_rx_byte_valid;
  assign tx_take   = parallel & i_tx_byte_taken;
  assign load_version = version_pending | i_standby;

  ram_access_seq ram_seq (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_start (ram_start),
    .i_ack   (i_ram_ack),
    .o_req   (seq_req),
    .o_done  (ram_done)
  );

  // ----------------------------------------------------------------------
  // ram word, address and control
  // ----------------------------------------------------------------------
  logic [7:0] next_control;

  // completion clears the request bit; a fresh request in the same
  // cycle would be refused by the sequencer anyway, so completion wins
  always_comb begin
    next_control = ram_control;
    if (wr_ctrl) begin
      next_control = i_host_data;
    end
    if (ram_done) begin
      next_control[modem_host_port_pkg::CTL_REQUEST] = 1'b0;
    end
  end

  // ram word holds host data for a write, core data after a read
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ram_word_low_byte  <= modem_host_port_pkg::BYTE_RESET;
      ram_word_high_byte <= modem_host_port_pkg::BYTE_RESET;
    end else if (ram_done & ~o_ram_we) begin
      ram_word_low_byte  <= i_ram_rdata[7:0];
      ram_word_high_byte <= i_ram_rdata[15:8];
    end else begin
      if (wr_low) begin
        ram_word_low_byte <= i_host_data;
      end
      if (wr_high) begin
        ram_word_high_byte <= i_host_data;
      end
    end
  end

  // control and low address byte
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ram_control       <= modem_host_port_pkg::CONTROL_RESET;
      ram_addr_low_byte <= modem_host_port_pkg::BYTE_RESET;
      frame_control     <= modem_host_port_pkg::FRAME_RESET;
    end else begin
      ram_control <= next_control;
      if (wr_addr) begin
        ram_addr_low_byte <= i_host_data;
      end
      if (wr_frame) begin
        frame_control <= i_host_data[modem_host_port_pkg::FRAME_BITS-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // parallel link byte and status flags
  // ----------------------------------------------------------------------
  // version load beats a received byte, which beats a host write
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      parallel_link_byte <= modem_host_port_pkg::BYTE_RESET;
      version_pending    <= 1'b1;
    end else begin
      version_pending <= 1'b0;
      if (load_version) begin
        parallel_link_byte <= FW_VERSION;
      end else if (rx_take) begin
        parallel_link_byte <= i_rx_byte;
      end else if (wr_link) begin
        parallel_link_byte <= i_host_data;
      end
    end
  end

  // flags: hardware set wins over the clearing access
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ram_done_flag <= 1'b0;
      rx_byte_flag  <= modem_host_port_pkg::RX_FLAG_RESET;
      tx_byte_flag  <= 1'b0;
    end else begin
      ram_done_flag <= ram_done | (ram_done_flag & ~ram_start);
      rx_byte_flag  <= rx_take | (rx_byte_flag & ~rd_link);
      tx_byte_flag  <= tx_take | (tx_byte_flag & ~wr_link);
    end
  end

  // ----------------------------------------------------------------------
  // read mux, interrupt and pin outputs
  // ----------------------------------------------------------------------
  logic [7:0] status_byte;
  logic [7:0] read_value;
  logic       irq_cause;
  logic       send_request;

  assign status_byte = {tx_byte_flag, rx_byte_flag, ram_done_flag,
                        i_pump_busy, 1'b0, i_retrain, i_carrier_detect,
                        i_pump_in_reset};

  // write-only and unassigned numbers read as zero
  assign read_value =
      hit(i_host_addr, modem_host_port_pkg::REG_RAM_DATA_LOW)
        ? ram_word_low_byte :
      hit(i_host_addr, modem_host_port_pkg::REG_RAM_DATA_HIGH)
        ? ram_word_high_byte :
      hit(i_host_addr, modem_host_port_pkg::REG_PARALLEL_LINK)
        ? parallel_link_byte :
      hit(i_host_addr, modem_host_port_pkg::REG_RAM_CONTROL)
        ? ram_control :
      hit(i_host_addr, modem_host_port_pkg::REG_PUMP_STATUS)
        ? status_byte :
      hit(i_host_addr, modem_host_port_pkg::REG_FRAME_STATUS)
        ? {5'h00, i_frame_status} : 8'h00;

  // rx and tx interrupts only count in parallel mode
  assign irq_cause =
      (ram_done_flag & ram_control[modem_host_port_pkg::CTL_RAM_IE])
    | (rx_byte_flag & parallel
       & ram_control[modem_host_port_pkg::CTL_RX_IE])
    | (tx_byte_flag & parallel
       & ram_control[modem_host_port_pkg::CTL_TX_IE]);

  // pin is active low, so the register bit covers for a high pin
  assign send_request = ram_control[modem_host_port_pkg::CTL_SEND_REQ]
                      | ~i_rts_n;

  // all pin outputs registered; one cycle behind their causes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_host_data            <= 8'h00;
      o_host_data_oe_n       <= 1'b1;
      o_host_irq_n           <= 1'b1;
      o_send_request         <= 1'b0;
      o_rx_serial            <= modem_host_port_pkg::MARK_LEVEL;
      o_line_signal_detect_n <= 1'b1;
    end else begin
      o_host_data            <= read_value;
      o_host_data_oe_n       <= ~rd_active;
      o_host_irq_n           <= ~irq_cause;
      o_send_request         <= send_request;
      o_rx_serial            <= i_carrier_detect ? i_rx_serial
                                : modem_host_port_pkg::MARK_LEVEL;
      o_line_signal_detect_n <= ~i_carrier_detect;
    end
  end

  // ram port and link mirrors straight from their registers
  assign o_ram_req              = seq_req;
  assign o_ram_we               = ram_control[
                                    modem_host_port_pkg::CTL_DIRECTION];
  assign o_ram_addr             = {ram_control[
                                    modem_host_port_pkg::CTL_ADDR_TOP],
                                   ram_addr_low_byte};
  assign o_ram_wdata            = {ram_word_high_byte, ram_word_low_byte};
  assign o_tx_byte              = parallel_link_byte;
  assign o_parallel_path_select = parallel;
  assign o_frame_control        = frame_control;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_req_bit_clears: assert property (@(posedge i_clk) disable iff (i_rst)
    ram_done |=> !ram_control[modem_host_port_pkg::CTL_REQUEST])
    else $error("request bit not cleared after completion");

  a_done_flag_sets: assert property (@(posedge i_clk) disable iff (i_rst)
    ram_done |=> ram_done_flag)
    else $error("ram done flag not set");

  a_rx_flag_sets: assert property (@(posedge i_clk) disable iff (i_rst)
    rx_take |=> rx_byte_flag && parallel_link_byte == $past(i_rx_byte)
      || $past(load_version))
    else $error("rx byte not captured with flag");

  a_rx_read_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_link && !rx_take |=> !rx_byte_flag)
    else $error("rx flag not cleared by read");

  a_tx_write_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_link && !tx_take |=> !tx_byte_flag)
    else $error("tx flag not cleared by write");

  a_irq_follows: assert property (@(posedge i_clk) disable iff (i_rst)
    ram_done_flag && ram_control[modem_host_port_pkg::CTL_RAM_IE]
      |=> !o_host_irq_n)
    else $error("irq not raised for enabled flag");

  a_rx_mark_clamp: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_carrier_detect |=> o_rx_serial == modem_host_port_pkg::MARK_LEVEL)
    else $error("rx serial not clamped to mark");

  a_send_or_pin: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rts_n |=> o_send_request)
    else $error("pin send request lost");

  a_unassigned_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_active && i_host_addr == modem_host_port_pkg::REG_UNASSIGNED
      |=> o_host_data == 8'h00)
    else $error("register 6 read not zero");

  a_standby_version: assert property (@(posedge i_clk) disable iff (i_rst)
    i_standby |=> parallel_link_byte == FW_VERSION)
    else $error("version not loaded in standby");
endmodule
`default_nettype wire

/* modem_host_register_port_tb.sv */
// self-checking bench for the modem host register port
// assumes: pump_core_model serves ram requests; bench drives host pins
`timescale 1ns/1ps
`default_nettype none
module modem_host_register_port_tb;
  localparam logic [7:0] FW = 8'h5A;  // arbitrary version value
  logic clk, rst, cs_n, rd_n, wr_n, ram_req, ram_we, ram_ack, irq_n, oe_n;
  logic rx_valid, tx_taken, path_sel, rts_n, send_req, standby, lsd_n;
  logic in_reset, carrier, retrain, busy, rx_ser_in, rx_ser;
  logic [2:0]  addr, frame_in, frame_ctl;
  logic [7:0]  wdata, rdata, rx_byte, tx_byte;
  logic [8:0]  ram_addr;
  logic [15:0] ram_wdata, ram_rdata;
  logic [3:0]  delay;
  int          miscompares, checks;

  modem_host_register_port #(.FW_VERSION(FW)) i_modem_host_register_port (
    .i_clk(clk), .i_rst(rst), .i_host_addr(addr), .i_host_data(wdata),
    .o_host_data(rdata), .o_host_data_oe_n(oe_n), .i_host_cs_n(cs_n),
    .i_host_rd_n(rd_n), .i_host_wr_n(wr_n), .o_host_irq_n(irq_n),
    .o_ram_req(ram_req), .o_ram_we(ram_we), .o_ram_addr(ram_addr),
    .o_ram_wdata(ram_wdata), .i_ram_ack(ram_ack), .i_ram_rdata(ram_rdata),
    .i_rx_byte_valid(rx_valid), .i_rx_byte(rx_byte), .o_tx_byte(tx_byte),
    .i_tx_byte_taken(tx_taken), .o_parallel_path_select(path_sel),
    .i_rts_n(rts_n), .o_send_request(send_req), .i_standby(standby),
    .i_pump_in_reset(in_reset), .i_carrier_detect(carrier),
    .i_retrain(retrain), .i_pump_busy(busy), .i_frame_status(frame_in),
    .o_frame_control(frame_ctl), .i_rx_serial(rx_ser_in),
    .o_rx_serial(rx_ser), .o_line_signal_detect_n(lsd_n));

  pump_core_model i_pump_core_model (
    .i_clk(clk), .i_rst(rst), .i_delay(delay), .i_req(ram_req),
    .i_we(ram_we), .i_addr(ram_addr), .i_wdata(ram_wdata),
    .o_ack(ram_ack), .o_rdata(ram_rdata));

  // ----------------------------------------------------------------------
  // clock, compare and host bus tasks
  // ----------------------------------------------------------------------
  always #5 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string msg);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // strobe held one edge, then a one-cycle gap before the next access
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
  endtask

  // data sampled two edges in, where the registered answer has landed
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    addr <= a;
    repeat (2) @(posedge clk);
    #1;
    check(oe_n, 1'b0, "read enable");
    d = rdata;
    @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
  endtask

  // start a ram access and poll the request bit with a bounded count
  task automatic ram_op(input logic [8:0] a, input logic we,
                        input logic [7:0] ctl);
    logic [7:0] d;
    wr(3'h2, a[7:0]);
    wr(3'h4, ctl | {5'h00, we, 1'b1, a[8]});
    for (int i = 0; i < 40; i++) begin
      rd(3'h4, d);
      if (!d[1])
        break;
    end
    check(d[1], 1'b0, "request bit not cleared");
  endtask

  task automatic wrap_up;
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [7:0]  d, b;
    logic [15:0] w;
    logic [8:0]  a;
    logic [4:0]  s;
    logic [2:0]  f;
    clk = 0; rst = 1; cs_n = 1; rd_n = 1; wr_n = 1; addr = 0; wdata = 0;
    rx_valid = 0; rx_byte = 0; tx_taken = 0; standby = 0; delay = 0;
    rts_n = 1;  // pin held high while the register bit is used
    in_reset = 0; carrier = 0; retrain = 0; busy = 0; rx_ser_in = 0;
    frame_in = 0;
    void'($urandom(5));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(3'h4, d); check(d, 8'h00, "control reset");
    rd(3'h3, d); check(d, FW, "version after reset");
    wr(3'h6, 8'hFF); rd(3'h6, d); check(d, 8'h00, "reg six");
    wr(3'h2, 8'hC3); rd(3'h2, d); check(d, 8'h00, "address read");
    // status pins and serial clamp under random line conditions
    for (int n = 0; n < 6; n++) begin
      s = 5'($urandom);
      {rx_ser_in, busy, retrain, carrier, in_reset} <= s;
      rd(3'h5, d);
      check(d & 8'h1F, {3'h0, s[3], 1'b0, s[2:0]}, "status");
      check(rx_ser, s[1] ? s[4] : 1'b1, "serial clamp");
      check(lsd_n, {~s[1]}, "detect pin");
    end
    // ram write then read back, both sides of the 255 boundary
    for (int n = 0; n < 8; n++) begin
      a = (n == 0) ? 9'h0FF : (n == 1) ? 9'h100 : 9'($urandom);
      w = 16'($urandom);
      delay <= 4'($urandom_range(0, 6));
      wr(3'h0, w[7:0]);
      wr(3'h1, w[15:8]);
      ram_op(a, 1'b1, 8'h20);
      @(posedge clk); #1;
      check(irq_n, 1'b0, "ram done irq");
      rd(3'h5, d); check(d[5], 1'b1, "ram done flag");
      wr(3'h0, ~w[7:0]);
      wr(3'h1, ~w[15:8]);
      ram_op(a, 1'b0, 8'h00);
      rd(3'h0, d); check(d, w[7:0], "ram low byte");
      rd(3'h1, d); check(d, w[15:8], "ram high byte");
      #1; check(irq_n, 1'b1, "irq masked");
    end
    // send request is register bit or pin
    for (int k = 0; k < 4; k++) begin
      rts_n <= k[0] | k[1];  // pin held high while the bit is used
      wr(3'h4, {4'h0, k[0], 3'h0});
      repeat (2) @(posedge clk); #1;
      check(send_req, {k[0] | ~k[1]}, "send request");
    end
    rts_n <= 1'b1;
    // parallel receive with its interrupt
    wr(3'h4, 8'h50); rd(3'h3, d); #1;
    check(path_sel, 1'b1, "parallel select");
    check(irq_n, 1'b1, "rx irq idle");
    for (int k = 0; k < 4; k++) begin
      b = 8'($urandom);
      @(posedge clk); rx_valid <= 1'b1; rx_byte <= b;
      @(posedge clk); rx_valid <= 1'b0;
      repeat (2) @(posedge clk); #1;
      check(irq_n, 1'b0, "rx irq");
      rd(3'h3, d); check(d, b, "rx byte");
      rd(3'h5, d); check(d[6], 1'b0, "rx flag clear");
      #1; check(irq_n, 1'b1, "rx irq clear");
    end
    // parallel transmit with its interrupt
    wr(3'h4, 8'h90);
    for (int k = 0; k < 4; k++) begin
      b = 8'($urandom);
      wr(3'h3, b); @(posedge clk); #1;
      check(tx_byte, b, "tx byte");
      rd(3'h5, d); check(d[7], 1'b0, "tx flag clear");
      @(posedge clk); tx_taken <= 1'b1;
      @(posedge clk); tx_taken <= 1'b0;
      repeat (2) @(posedge clk); #1;
      check(irq_n, 1'b0, "tx irq");
      rd(3'h5, d); check(d[7], 1'b1, "tx flag set");
    end
    wr(3'h4, 8'h00);
    // standby reloads the version over a host write
    standby <= 1'b1; wr(3'h3, 8'h33);
    rd(3'h3, d); check(d, FW, "version in standby");
    standby <= 1'b0;
    f = 3'($urandom); frame_in <= ~f; wr(3'h7, {5'h1F, f});
    rd(3'h7, d); check(d[2:0], {~f}, "frame status");
    check(frame_ctl, f, "frame control");
    wrap_up();
  end
endmodule
`default_nettype wire

/* pump_core_model.sv */
// pump core stand-in: internal ram answering the host port's requests
// assumes: request held from start until one cycle after its acknowledge
`timescale 1ns/1ps
`default_nettype none
module pump_core_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [3:0]  i_delay,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [8:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  output logic             o_ack,
  output logic [15:0]      o_rdata
);
  logic [15:0] mem [0:511];
  logic        served;
  logic [3:0]  waited;
  // ----------------------------------------------------------------------
  // one access per request, after a programmable wait
  // ----------------------------------------------------------------------
  // rdata flips every cycle except a read's ack cycle so a stale word never looks valid
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      served <= 1'b0;
      waited <= 4'h0;
      o_rdata <= 16'hA5A5;
    end else begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (!i_req) begin
        served <= 1'b0;
        waited <= 4'h0;
      end else if (!served && waited >= i_delay) begin
        o_ack <= 1'b1;
        served <= 1'b1;
        if (i_we)
          mem[i_addr] <= i_wdata;
        else
          o_rdata <= mem[i_addr];
      end else if (!served) begin
        waited <= waited + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* ram_access_seq.sv */
// ram access sequencer: holds a request to the pump core until it answers
// assumes: the core raises i_ack for one cycle per accepted request
`timescale 1ns/1ps
`default_nettype none
module ram_access_seq (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_start,
  input  wire logic i_ack,
  output logic      o_req,
  output logic      o_done
);
  typedef enum logic {SEQ_IDLE, SEQ_WAIT} seq_state_t;
  seq_state_t state;
  seq_state_t next_state;

  // done only for an ack that answers our own request
  assign o_done = (state == SEQ_WAIT) & i_ack;

  // next state
  always_comb begin
    next_state = state;
    case (state)
      SEQ_IDLE: begin
        if (i_start) begin
          next_state = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        if (i_ack) begin
          next_state = SEQ_IDLE;
        end
      end
      default: begin
        next_state = SEQ_IDLE;
      end
    endcase
  end

  // state and request level
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= SEQ_IDLE;
      o_req <= 1'b0;
    end else begin
      state <= next_state;
      o_req <= (next_state == SEQ_WAIT);
    end
  end
endmodule
`default_nettype wire
